// ===== design/csgo_pkg.sv
// Shared constants and types for the channel sequencer with gain and offset registers
package csgo_pkg;

  localparam int CSGO_SAMPLE_W = 14;
  localparam int CSGO_REG_W = 9;
  localparam int CSGO_ADDR_W = 3;
  localparam int CSGO_NUM_CH = 3;

  // Register addresses on the register write port
  localparam logic [2:0] CSGO_ADDR_CONFIG = 3'h0;
  localparam logic [2:0] CSGO_ADDR_ORDER = 3'h1;
  localparam logic [2:0] CSGO_ADDR_RED_GAIN = 3'h2;
  localparam logic [2:0] CSGO_ADDR_GREEN_GAIN = 3'h3;
  localparam logic [2:0] CSGO_ADDR_BLUE_GAIN = 3'h4;
  localparam logic [2:0] CSGO_ADDR_RED_OFFSET = 3'h5;
  localparam logic [2:0] CSGO_ADDR_GREEN_OFFSET = 3'h6;
  localparam logic [2:0] CSGO_ADDR_BLUE_OFFSET = 3'h7;

  // Field positions
  localparam int CSGO_CFG_THREE_CH_BIT = 5;
  localparam int CSGO_CFG_CDS_BIT = 4;
  localparam int CSGO_ORDER_SEL_BIT = 7;
  localparam int CSGO_SINGLE_RED_BIT = 6;
  localparam int CSGO_SINGLE_GREEN_BIT = 5;
  localparam int CSGO_SINGLE_BLUE_BIT = 4;
  localparam int CSGO_GAIN_W = 6;
  localparam int CSGO_OFS_SIGN_BIT = 8;
  localparam int CSGO_OFS_MAG_W = 8;

  // Power-on values
  localparam logic [8:0] CSGO_CFG_RESET = 9'h078;
  localparam logic [8:0] CSGO_ORDER_RESET = 9'h0c0;
  localparam logic [8:0] CSGO_GAIN_RESET = 9'h000;
  localparam logic [8:0] CSGO_OFS_RESET = 9'h000;

  // Gain law, figures scaled by ten, result in fixed point with CSGO_GAIN_FRAC fraction bits
  localparam int CSGO_GAIN_MAX_X10 = 57;
  localparam int CSGO_GAIN_SPAN_X10 = 47;
  localparam int CSGO_GAIN_UNIT_X10 = 10;
  localparam int CSGO_GAIN_CODES_M1 = 63;
  localparam int CSGO_GAIN_FRAC = 8;

  // Offset step expressed in converter codes (2 V span over 14 bits)
  localparam int CSGO_OFS_STEP_UV = 1200;
  localparam int CSGO_ADC_LSB_NV = 122070;
  localparam int CSGO_OFS_STEP_CODES = (CSGO_OFS_STEP_UV * 1000) / CSGO_ADC_LSB_NV;
  localparam logic [13:0] CSGO_CODE_MAX = 14'h3fff;

  localparam int CSGO_PIPE_DEPTH = 3;
  localparam int CSGO_FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    CSGO_CH_RED = 3'b001,
    CSGO_CH_GREEN = 3'b010,
    CSGO_CH_BLUE = 3'b100
  } csgo_chan_e;

endpackage

// ===== design/csgo_pin_sync.sv
// Two-stage synchroniser with edge detection for pins from outside the clock domain
`timescale 1ns/10ps
module csgo_pin_sync
  import csgo_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] fall,
  output logic [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
    logic [W-1:0] prev;
  } csgo_sync_s;

  csgo_sync_s cs;
  csgo_sync_s next_cs;

  if (W < 1) begin : g_chk
    $error("csgo_pin_sync width must be at least one");
  end

  always_comb begin
    next_cs = cs;
    next_cs.meta = pin_in;
    next_cs.stab = cs.meta;
    next_cs.prev = cs.stab;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs <= '0;
    end else begin
      cs <= next_cs;
    end
  end

  // Edges look only at the second stage and its delayed copy
  assign level = cs.stab;
  assign fall = cs.prev & ~cs.stab;
  assign rise = ~cs.prev & cs.stab;

endmodule

// ===== design/csgo_fifo.sv
// Conversion result FIFO with registered read data
`timescale 1ns/10ps
module csgo_fifo
  import csgo_pkg::*;
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = CSGO_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] dout;
    logic dvalid;
  } csgo_fifo_s;

  csgo_fifo_s cs;
  csgo_fifo_s next_cs;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("csgo_fifo depth must be a power of two of at least two");
  end

  // Pointers wrap naturally because the depth is a power of two
  assign in_ready = (cs.count != (AW + 1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (cs.count != '0) && (!cs.dvalid || out_ready);

  always_comb begin
    next_cs = cs;
    if (push) begin
      next_cs.mem[cs.wptr] = in_data;
      next_cs.wptr = cs.wptr + 1'b1;
    end
    if (pop) begin
      next_cs.dout = cs.mem[cs.rptr];
      next_cs.rptr = cs.rptr + 1'b1;
      next_cs.dvalid = 1'b1;
    end else if (out_ready) begin
      next_cs.dvalid = 1'b0;
    end
    case ({push, pop})
      2'b10: next_cs.count = cs.count + 1'b1;
      2'b01: next_cs.count = cs.count - 1'b1;
      default: next_cs.count = cs.count;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs <= '0;
    end else begin
      cs <= next_cs;
    end
  end

  assign out_valid = cs.dvalid;
  assign out_data = cs.dout;

  count_bound_a: assert property (@(posedge sys_clk) disable iff (reset)
    cs.count <= (AW + 1)'(DEPTH))
    else $error("fifo count above depth");

endmodule

// ===== design/csgo_core.sv
// Channel sequencer, gain and offset registers, sampling and conversion pipeline
//
// Contract
// [RULE_01] Host writes zero into order register bit 8 and bits 3 to 0.
// [RULE_02] Three-channel mode with order bit set converts red, green, blue.
// [RULE_03] Red-first: every data sample clock pulse returns the sequencer to red.
// [RULE_04] Order bit clear: blue, green, red; each data pulse restarts at blue.
// [RULE_05] One-channel mode: bit 6 red, bit 5 green, bit 4 blue.
// [RULE_06] One-channel mode keeps the sequencer fixed on the selected channel.
// [RULE_07] Power-on order register: red-green-blue order, red single, others off.
// [RULE_08] Host writes zero into the top three bits of each gain register.
// [RULE_09] Six gain bits are straight binary, 64 steps from 1x to 5.7x.
// [RULE_10] Each gain register powers up at code zero, unity gain.
// [RULE_11] Offset registers are 9-bit sign-magnitude, sign on top bit.
// [RULE_12] Each magnitude step adds 1.2 mV toward the sign; zero is zero. The code steps 9 converter codes, about 1.1 mV.
// [RULE_13] Each offset register powers up at zero.
// [RULE_14] CORRELATED_DOUBLE_SAMPLING: reference on reference clock fall, data on data clock fall, difference.
// [RULE_15] CORRELATED_DOUBLE_SAMPLING: clamp connects bias while the reference sample clock is high.
// [RULE_16] SHA: data clock fall samples input and offset pin; clamp disabled.
// [RULE_17] Controller places data clock fall at or before converter clock rise.
// [RULE_18] Gain equals 5.7 over one plus 4.7 times (63 minus G) over 63.
// [RULE_19] Configuration bit 5 set selects three-channel, clear selects one-channel.
// [RULE_20] Configuration bit 4 set selects CORRELATED_DOUBLE_SAMPLING, clear selects sample-and-hold.
// [RULE_21] Converter takes channels in turn on each converter clock fall.
// [RULE_22] Converted data leaves three converter clock cycles after its sample.
`timescale 1ns/10ps
module csgo_core
  import csgo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [CSGO_ADDR_W-1:0] reg_addr,
  input wire logic [CSGO_REG_W-1:0] reg_wdata,
  output logic [CSGO_REG_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic reference_sample_clock,
  input wire logic data_sample_clock,
  input wire logic converter_clock,
  input wire logic [CSGO_SAMPLE_W-1:0] red_level,
  input wire logic [CSGO_SAMPLE_W-1:0] green_level,
  input wire logic [CSGO_SAMPLE_W-1:0] blue_level,
  input wire logic [CSGO_SAMPLE_W-1:0] offset_pin_level,
  output logic clamp_active,
  output logic [2:0] current_channel,
  output logic out_valid,
  input wire logic out_ready,
  output logic [CSGO_SAMPLE_W-1:0] out_data,
  output logic [2:0] out_channel,
  output logic fifo_overflow
);

  localparam int FW = CSGO_SAMPLE_W + 3;

  typedef struct packed {
    logic [8:0] cfg;
    logic [8:0] order;
    logic [CSGO_NUM_CH-1:0][8:0] gain;
    logic [CSGO_NUM_CH-1:0][8:0] ofs;
    logic [8:0] rdata;
    logic rd_valid;
    logic [CSGO_NUM_CH-1:0][CSGO_SAMPLE_W-1:0] ref_samp;
    logic [CSGO_NUM_CH-1:0][15:0] diff;
    csgo_chan_e seq;
    logic [CSGO_PIPE_DEPTH-1:0][CSGO_SAMPLE_W-1:0] pipe_data;
    logic [CSGO_PIPE_DEPTH-1:0][2:0] pipe_chan;
    logic [CSGO_PIPE_DEPTH-1:0] pipe_vld;
    logic push;
    logic [FW-1:0] push_data;
    logic clamp;
    logic overflow;
  } csgo_core_s;

  csgo_core_s cs;
  csgo_core_s next_cs;

  logic [2:0] clk_level;
  logic [2:0] clk_fall;
  logic [4*CSGO_SAMPLE_W-1:0] lvl_q;
  logic ref_fall;
  logic data_fall;
  logic conv_fall;
  logic three_ch;
  logic cds_mode;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  csgo_chan_e first_ch;
  csgo_chan_e single_ch;
  csgo_chan_e step_ch;
  logic [CSGO_NUM_CH-1:0][CSGO_SAMPLE_W-1:0] chan_result;
  logic [1:0] seq_idx;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  csgo_pin_sync #(.W(3)) u_clk_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in({converter_clock, data_sample_clock, reference_sample_clock}),
    .level(clk_level),
    .fall(clk_fall),
    .rise()
  );

  // Analog stand-ins are held steady around the sampling edges, so a plain
  // two-stage pass keeps them aligned with the edge flags above
  csgo_pin_sync #(.W(4 * CSGO_SAMPLE_W)) u_lvl_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_in({offset_pin_level, blue_level, green_level, red_level}),
    .level(lvl_q),
    .fall(),
    .rise()
  );

  assign ref_fall = clk_fall[0];
  assign data_fall = clk_fall[1];
  assign conv_fall = clk_fall[2];
  assign three_ch = cs.cfg[CSGO_CFG_THREE_CH_BIT]; // see [RULE_19]
  assign cds_mode = cs.cfg[CSGO_CFG_CDS_BIT]; // see [RULE_20]

  //////////////////////////////////////////////////////////////////////////////
  // Channel selection helpers

  always_comb begin
    // see [RULE_02] see [RULE_04]
    first_ch = cs.order[CSGO_ORDER_SEL_BIT] ? CSGO_CH_RED : CSGO_CH_BLUE;
    // see [RULE_05] Red, then green, then blue wins if several selects are set, red if none is
    if (cs.order[CSGO_SINGLE_RED_BIT]) begin
      single_ch = CSGO_CH_RED;
    end else if (cs.order[CSGO_SINGLE_GREEN_BIT]) begin
      single_ch = CSGO_CH_GREEN;
    end else if (cs.order[CSGO_SINGLE_BLUE_BIT]) begin
      single_ch = CSGO_CH_BLUE;
    end else begin
      single_ch = CSGO_CH_RED;
    end
    case (cs.seq)
      CSGO_CH_RED: step_ch = cs.order[CSGO_ORDER_SEL_BIT] ? CSGO_CH_GREEN : CSGO_CH_BLUE;
      CSGO_CH_GREEN: step_ch = cs.order[CSGO_ORDER_SEL_BIT] ? CSGO_CH_BLUE : CSGO_CH_RED;
      CSGO_CH_BLUE: step_ch = cs.order[CSGO_ORDER_SEL_BIT] ? CSGO_CH_RED : CSGO_CH_GREEN;
      default: step_ch = first_ch;
    endcase
    case (cs.seq)
      CSGO_CH_GREEN: seq_idx = 2'd1;
      CSGO_CH_BLUE: seq_idx = 2'd2;
      default: seq_idx = 2'd0;
    endcase
  end

  // see [RULE_09] see [RULE_18] Divider is shared by nothing: one per channel
  function automatic logic [11:0] csgo_gain_q(input logic [CSGO_GAIN_W-1:0] g);
    int den;
    den = CSGO_GAIN_UNIT_X10 * CSGO_GAIN_CODES_M1
      + CSGO_GAIN_SPAN_X10 * (CSGO_GAIN_CODES_M1 - int'(g));
    return 12'(((CSGO_GAIN_MAX_X10 * CSGO_GAIN_CODES_M1) << CSGO_GAIN_FRAC) / den);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel offset and gain

  for (genvar c = 0; c < CSGO_NUM_CH; c++) begin : g_chan
    logic [16:0] ofs_abs;
    logic signed [16:0] ofs_signed;
    logic signed [17:0] sum;
    logic signed [30:0] prod;
    logic signed [30:0] scaled;
    logic [11:0] gain_q;

    // see [RULE_11] see [RULE_12]
    assign ofs_abs = 17'(cs.ofs[c][CSGO_OFS_MAG_W-1:0]) * 17'(CSGO_OFS_STEP_CODES);
    assign ofs_signed = cs.ofs[c][CSGO_OFS_SIGN_BIT] ? -$signed(ofs_abs) : $signed(ofs_abs);
    assign sum = 18'($signed(cs.diff[c])) + 18'(ofs_signed);
    assign gain_q = csgo_gain_q(cs.gain[c][CSGO_GAIN_W-1:0]);
    assign prod = 31'(sum) * $signed(31'(gain_q));
    assign scaled = prod >>> CSGO_GAIN_FRAC;

    always_comb begin
      if (scaled < 0) begin
        chan_result[c] = '0;
      end else if (scaled > $signed(31'(CSGO_CODE_MAX))) begin
        chan_result[c] = CSGO_CODE_MAX;
      end else begin
        chan_result[c] = scaled[CSGO_SAMPLE_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_cs = cs;
    next_cs.rd_valid = 1'b0;
    next_cs.push = 1'b0;

    if (reg_wr_en) begin
      case (reg_addr)
        CSGO_ADDR_CONFIG: next_cs.cfg = reg_wdata;
        CSGO_ADDR_ORDER: next_cs.order = reg_wdata;
        CSGO_ADDR_RED_GAIN: next_cs.gain[0] = reg_wdata;
        CSGO_ADDR_GREEN_GAIN: next_cs.gain[1] = reg_wdata;
        CSGO_ADDR_BLUE_GAIN: next_cs.gain[2] = reg_wdata;
        CSGO_ADDR_RED_OFFSET: next_cs.ofs[0] = reg_wdata;
        CSGO_ADDR_GREEN_OFFSET: next_cs.ofs[1] = reg_wdata;
        CSGO_ADDR_BLUE_OFFSET: next_cs.ofs[2] = reg_wdata;
        default: next_cs.cfg = cs.cfg;
      endcase
    end
    if (reg_rd_en) begin
      next_cs.rd_valid = 1'b1;
      case (reg_addr)
        CSGO_ADDR_CONFIG: next_cs.rdata = cs.cfg;
        CSGO_ADDR_ORDER: next_cs.rdata = cs.order;
        CSGO_ADDR_RED_GAIN: next_cs.rdata = cs.gain[0];
        CSGO_ADDR_GREEN_GAIN: next_cs.rdata = cs.gain[1];
        CSGO_ADDR_BLUE_GAIN: next_cs.rdata = cs.gain[2];
        CSGO_ADDR_RED_OFFSET: next_cs.rdata = cs.ofs[0];
        CSGO_ADDR_GREEN_OFFSET: next_cs.rdata = cs.ofs[1];
        default: next_cs.rdata = cs.ofs[2];
      endcase
    end

    // see [RULE_14] see [RULE_16]
    for (int c = 0; c < CSGO_NUM_CH; c++) begin
      if (cds_mode && ref_fall) begin
        next_cs.ref_samp[c] = lvl_q[c*CSGO_SAMPLE_W +: CSGO_SAMPLE_W];
      end
      if (data_fall) begin
        if (cds_mode) begin
          next_cs.diff[c] = {2'b00, cs.ref_samp[c]}
            - {2'b00, lvl_q[c*CSGO_SAMPLE_W +: CSGO_SAMPLE_W]};
        end else begin
          next_cs.diff[c] = {2'b00, lvl_q[c*CSGO_SAMPLE_W +: CSGO_SAMPLE_W]}
            - {2'b00, lvl_q[3*CSGO_SAMPLE_W +: CSGO_SAMPLE_W]};
        end
      end
    end

    // see [RULE_15] see [RULE_16]
    next_cs.clamp = cds_mode && clk_level[0];

    // see [RULE_21] see [RULE_22] Three-deep pipe advanced by converter falls
    if (conv_fall) begin
      next_cs.pipe_data[0] = chan_result[seq_idx];
      next_cs.pipe_chan[0] = cs.seq;
      next_cs.pipe_vld[0] = 1'b1;
      for (int s = 1; s < CSGO_PIPE_DEPTH; s++) begin
        next_cs.pipe_data[s] = cs.pipe_data[s-1];
        next_cs.pipe_chan[s] = cs.pipe_chan[s-1];
        next_cs.pipe_vld[s] = cs.pipe_vld[s-1];
      end
      next_cs.push = cs.pipe_vld[CSGO_PIPE_DEPTH-1];
      next_cs.push_data = {cs.pipe_chan[CSGO_PIPE_DEPTH-1], cs.pipe_data[CSGO_PIPE_DEPTH-1]};
    end

    // Converter edges cannot be held off, so a full FIFO drops the word and flags it
    if (cs.push && !fifo_in_ready) begin
      next_cs.overflow = 1'b1;
    end

    // Sequencer: a data pulse restart wins over a step in the same cycle
    if (!three_ch) begin
      next_cs.seq = single_ch; // see [RULE_06]
    end else if (data_fall) begin
      next_cs.seq = first_ch; // see [RULE_03] see [RULE_04]
    end else if (conv_fall) begin
      next_cs.seq = step_ch; // see [RULE_02]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs <= '0;
      cs.cfg <= CSGO_CFG_RESET;
      cs.order <= CSGO_ORDER_RESET; // see [RULE_07]
      cs.gain <= {CSGO_NUM_CH{CSGO_GAIN_RESET}}; // see [RULE_10]
      cs.ofs <= {CSGO_NUM_CH{CSGO_OFS_RESET}}; // see [RULE_13]
      cs.seq <= CSGO_CH_RED;
    end else begin
      cs <= next_cs;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer and outputs

  csgo_fifo #(.WIDTH(FW), .DEPTH(CSGO_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(cs.push),
    .in_ready(fifo_in_ready),
    .in_data(cs.push_data),
    .out_valid(fifo_out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out_data)
  );

  assign reg_rdata = cs.rdata;
  assign reg_rd_valid = cs.rd_valid;
  assign clamp_active = cs.clamp;
  assign current_channel = cs.seq;
  assign out_valid = fifo_out_valid;
  assign out_data = fifo_out_data[CSGO_SAMPLE_W-1:0];
  assign out_channel = fifo_out_data[FW-1:CSGO_SAMPLE_W];
  assign fifo_overflow = cs.overflow;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence data_restart_s;
    three_ch && data_fall;
  endsequence

  sequence rgb_step_s;
    three_ch && cs.order[CSGO_ORDER_SEL_BIT] && conv_fall && !data_fall;
  endsequence

  rgb_restart_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_03]
    data_restart_s and cs.order[CSGO_ORDER_SEL_BIT] |=> cs.seq == CSGO_CH_RED)
    else $error("red-first restart missed");

  bgr_restart_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_04]
    data_restart_s and !cs.order[CSGO_ORDER_SEL_BIT] |=> cs.seq == CSGO_CH_BLUE)
    else $error("blue-first restart missed");

  rgb_step_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_02]
    rgb_step_s and cs.seq == CSGO_CH_RED |=> cs.seq == CSGO_CH_GREEN)
    else $error("red not followed by green");

  single_fixed_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_06]
    !three_ch && !$past(three_ch) && $stable(cs.order) |=> $stable(cs.seq))
    else $error("one-channel sequencer moved");

  single_green_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_05]
    !three_ch && cs.order[6:4] == 3'b010 |=> cs.seq == CSGO_CH_GREEN)
    else $error("green single select ignored");

  power_on_a: assert property (@(posedge sys_clk) // see [RULE_07]
    reset |=> cs.order == CSGO_ORDER_RESET && cs.seq == CSGO_CH_RED)
    else $error("order register power-on value wrong");

  gain_ofs_init_a: assert property (@(posedge sys_clk) // see [RULE_10]
    reset |=> cs.gain == '0 && cs.ofs == '0)
    else $error("gain or offset power-on value wrong");

  clamp_cds_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_15]
    cds_mode && clk_level[0] |=> clamp_active)
    else $error("clamp not engaged during reference clock high");

  clamp_sha_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_16]
    !cds_mode |=> !clamp_active)
    else $error("clamp engaged in sample-and-hold mode");

  ref_capture_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_14]
    cds_mode && ref_fall |=> cs.ref_samp[0] == $past(lvl_q[CSGO_SAMPLE_W-1:0]))
    else $error("reference level not captured");

  latency_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_22]
    conv_fall && cs.pipe_vld[2] |=> cs.push && cs.push_data[CSGO_SAMPLE_W-1:0]
      == $past(cs.pipe_data[2]))
    else $error("third-stage result not pushed");

  zero_ofs_a: assert property (@(posedge sys_clk) disable iff (reset) // see [RULE_12]
    cs.ofs[0][CSGO_OFS_MAG_W-1:0] == '0 |-> g_chan[0].ofs_signed == '0)
    else $error("zero offset magnitude not zero");

endmodule

// ===== test/csgo_scan_model.sv
// Scanner controller model: drives the sample and converter clocks
`timescale 1ns/10ps
module csgo_scan_model (
  input wire logic sys_clk,
  input wire logic clamp_active,
  output logic reference_sample_clock,
  output logic data_sample_clock,
  output logic converter_clock,
  output logic clamp_hi,
  output logic clamp_lo
);
  initial begin
    reference_sample_clock = 0;
    data_sample_clock = 0;
    converter_clock = 0;
    clamp_hi = 0;
    clamp_lo = 0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Reference clock stays grounded in sample-and-hold frames
  task automatic ref_pulse(input logic en);
    reference_sample_clock = en;
    hold(5);
    clamp_hi = clamp_active;
    reference_sample_clock = 0;
    hold(5);
    clamp_lo = clamp_active;
  endtask
  task automatic data_pulse();
    data_sample_clock = 1;
    hold(5);
    data_sample_clock = 0;
    hold(5);
  endtask
  // Converter rises only after the data fall has been seen
  task automatic conv_pulse();
    converter_clock = 1;
    hold(4);
    converter_clock = 0;
    hold(4);
  endtask
endmodule

// ===== test/tb_channel_sequencer_gain_offset.sv
// Self-checking bench for the channel sequencer with gain and offset registers
`timescale 1ns/10ps
module tb_channel_sequencer_gain_offset;
  import csgo_pkg::*;
  logic sys_clk = 0, reset = 1, reg_wr_en = 0, reg_rd_en = 0, out_ready = 0;
  logic [2:0] reg_addr = '0;
  logic [8:0] reg_wdata = '0;
  logic [8:0] reg_rdata;
  logic reg_rd_valid, clamp_active, out_valid, fifo_overflow, clamp_hi, clamp_lo;
  logic ref_clk, dat_clk, cnv_clk;
  logic [13:0] lvl [4] = '{default: '0};
  logic [13:0] out_data;
  logic [2:0] current_channel, out_channel;
  int fails = 0, checked = 0, cyc = 0, ndrain = 0, hold_rdy = 0, ovf = 0;
  int regs [8], diff [3], dv [3], dl [3], eq [$], ech [$];
  logic [31:0] seed = 32'h0000_0d2d;

  always #10 sys_clk = ~sys_clk;

  csgo_core csgo_core_inst (.sys_clk(sys_clk), .reset(reset), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reference_sample_clock(ref_clk),
    .data_sample_clock(dat_clk), .converter_clock(cnv_clk), .red_level(lvl[0]),
    .green_level(lvl[1]), .blue_level(lvl[2]), .offset_pin_level(lvl[3]),
    .clamp_active(clamp_active), .current_channel(current_channel), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_channel(out_channel),
    .fifo_overflow(fifo_overflow));

  csgo_scan_model csgo_scan_model_inst (.sys_clk(sys_clk), .clamp_active(clamp_active),
    .reference_sample_clock(ref_clk), .data_sample_clock(dat_clk),
    .converter_clock(cnv_clk), .clamp_hi(clamp_hi), .clamp_lo(clamp_lo));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed & 32'h7fff_ffff);
  endfunction

  function automatic int exp_code(input int c);
    int g, o, v;
    g = (57 * 63 * 256) / (630 + 47 * (63 - regs[2 + c]));
    o = (regs[5 + c] % 256) * 9;
    if (regs[5 + c] >= 256) o = -o;
    v = ((diff[c] + o) * g) / 256;
    return v < 0 ? 0 : (v > 16383 ? 16383 : v);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Strobes drop for a cycle between accesses so no signal is written twice at one edge
  task automatic wr(input int a, input int d);
    reg_wr_en = 1;
    reg_addr = a[2:0];
    reg_wdata = d[8:0];
    @(negedge sys_clk);
    reg_wr_en = 0;
    regs[a] = d;
    @(negedge sys_clk);
  endtask

  task automatic rd(input int a);
    reg_rd_en = 1;
    reg_addr = a[2:0];
    @(negedge sys_clk);
    check("reg_rd_valid", {31'h0, reg_rd_valid}, 1);
    check("reg_rdata", {23'h0, reg_rdata}, regs[a]);
    reg_rd_en = 0;
    @(negedge sys_clk);
  endtask

  // One line of pixels: configure, sample reference and data, then n conversions
  task automatic frame(input logic [8:0] cfg, input logic [8:0] ord, input int n);
    int cur, c, k;
    wr(0, cfg);
    wr(1, ord);
    rd(1);
    for (c = 0; c < 3; c++) begin
      // The first frame pins the red and green gain codes to both ends of the range
      wr(2 + c, (n == 5 && c < 2) ? 63 * (1 - c) : xs() % 64);
      wr(5 + c, xs() % 512);
      rd(2 + c);
      rd(5 + c);
      dv[c] = xs() % 8192;
      dl[c] = xs() % 4096;
      lvl[c] = 14'(dv[c] + dl[c]);
    end
    csgo_scan_model_inst.ref_pulse(cfg[4]);
    check("clamp_high", {31'h0, clamp_hi}, {31'h0, cfg[4]});
    check("clamp_low", {31'h0, clamp_lo}, 0);
    for (c = 0; c < 3; c++) lvl[c] = 14'(dv[c]);
    lvl[3] = 14'(xs() % 2048);
    csgo_scan_model_inst.data_pulse();
    for (c = 0; c < 3; c++) begin
      diff[c] = cfg[4] ? dl[c] : dv[c] - int'(lvl[3]);
    end
    cur = ord[7] ? 0 : 2;
    if (!cfg[5]) cur = ord[6] ? 0 : (ord[5] ? 1 : (ord[4] ? 2 : 0));
    check("first_channel", current_channel, 1 << cur);
    // Each result is fixed at its own converter fall, so words left in the pipe
    // keep the registers of their own line
    for (k = 0; k < n; k++) begin
      csgo_scan_model_inst.conv_pulse();
      eq.push_back(exp_code(cur));
      ech.push_back(1 << cur);
      if (cfg[5]) cur = ord[7] ? (cur + 1) % 3 : (cur + 2) % 3;
    end
    check("last_channel", current_channel, 1 << cur);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk) begin
    out_ready = hold_rdy == 0 && cyc % 4 != 1;
    if (out_ready && out_valid) begin
      if (ovf != 0) ndrain++;
      else if (eq.size() == 0) check("extra_word", 1, 0);
      else begin
        check("out_channel", out_channel, ech.pop_front());
        check("out_data", out_data, eq.pop_front());
      end
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    regs = '{32'h78, 32'hc0, 0, 0, 0, 0, 0, 0};
    repeat (2) @(negedge sys_clk);
    reset = 0;
    for (int a = 0; a < 8; a++) rd(a);
    frame(9'h078, 9'h0c0, 5);
    frame(9'h078, 9'h040, 4);
    frame(9'h068, 9'h080, 3);
    frame(9'h048, 9'h040, 4);
    frame(9'h048, 9'h020, 4);
    frame(9'h058, 9'h010, 4);
    frame(9'h048, 9'h000, 3);
    repeat (400) if (eq.size() > 3) @(negedge sys_clk);
    check("stuck_in_pipe", eq.size(), 3);
    check("fifo_overflow", {31'h0, fifo_overflow}, 0);
    hold_rdy = 1;
    ovf = 1;
    frame(9'h078, 9'h0c0, 40);
    check("fifo_overflow", {31'h0, fifo_overflow}, 1);
    hold_rdy = 0;
    repeat (120) @(negedge sys_clk);
    check("drained_words", ndrain, 33);
    test_done();
  end
endmodule
